/* File: verilog/pss_map.svh */
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// register byte offsets
`define PSS_OFF_CTRL 7'h00
`define PSS_OFF_SOURCE 7'h04
`define PSS_OFF_STATUS 7'h08
`define PSS_OFF_LOOPREF 7'h0C
`define PSS_PRESET_PAGE_BIT 6

// control register fields
`define PSS_CTRL_LEVEL_LSB 0
`define PSS_CTRL_PRIM_LSB 2
`define PSS_CTRL_LOOPEN_BIT 4
`define PSS_CTRL_RESET 5'h01

// source register fields, one 4-bit code per selector
`define PSS_SRC_FIELD_W 4
`define PSS_SOURCE_RESET 16'h0043

// status register fields
`define PSS_STAT_INDEX_LSB 0
`define PSS_STAT_ACTIVE_LSB 4
`define PSS_STAT_ORDER_BIT 8
`define PSS_STAT_VALID_BIT 9

// encodings
`define PSS_LEVEL_EXPERT 2'h3
`define PSS_PRIM_REMOTE 2'h3

// process-loop scaling
`define PSS_LOOP_MUL 20'h0000A
`define PSS_LOOP_DIV 20'h0000F

`define PSS_PRESET_RESET 16'h0000

`endif

/* File: verilog/pss_pkg.sv */
package pss_pkg;

  typedef enum logic [1:0] {
    PSS_BUS_IDLE = 2'b00,
    PSS_BUS_FETCH = 2'b01,
    PSS_BUS_ANSWER = 2'b10
  } pss_bus_state_t;

  typedef enum logic [3:0] {
    PSS_SRC_NONE = 4'h0,
    PSS_SRC_DISC1 = 4'h1,
    PSS_SRC_DISC2 = 4'h2,
    PSS_SRC_DISC3 = 4'h3,
    PSS_SRC_DISC4 = 4'h4,
    PSS_SRC_DISC5 = 4'h5,
    PSS_SRC_DISC6 = 4'h6,
    PSS_SRC_NET11 = 4'h7,
    PSS_SRC_NET12 = 4'h8,
    PSS_SRC_NET13 = 4'h9,
    PSS_SRC_NET14 = 4'hA,
    PSS_SRC_NET15 = 4'hB
  } pss_src_t;

endpackage

/* File: verilog/pss_preset_ram.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_preset_ram
  import pss_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // bus write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  // speed read port, slot zero is the main reference
  input wire logic [3:0] sel_addr,
  input wire logic [15:0] base_data,
  output logic [15:0] sel_data,
  // bus read port
  input wire logic [3:0] bus_addr,
  output logic [15:0] bus_data
);

  `include "pss_map.svh"

  logic [15:0] mem_q [1:15];
  logic [15:0] sel_data_q;
  logic [15:0] bus_data_q;

  wire logic [15:0] sel_word = (sel_addr == 4'h0) ? base_data : mem_q[sel_addr];
  wire logic [15:0] bus_word = (bus_addr == 4'h0) ? 16'h0000 : mem_q[bus_addr];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 1; i <= 15; i++) begin
        mem_q[i] <= `PSS_PRESET_RESET;
      end
    end else if (wr_en && (wr_addr != 4'h0)) begin
      if (wr_be[0]) begin
        mem_q[wr_addr][7:0] <= wr_data[7:0];
      end
      if (wr_be[1]) begin
        mem_q[wr_addr][15:8] <= wr_data[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_data_q <= 16'h0000;
      bus_data_q <= 16'h0000;
    end else begin
      sel_data_q <= sel_word;
      bus_data_q <= bus_word;
    end
  end

  assign sel_data = sel_data_q;
  assign bus_data = bus_data_q;

endmodule

`default_nettype wire

/* File: verilog/pss_top.sv */
// Functional notes
// - index is sixteen,eight,four,two selector bits; zero picks main reference, n picks n+1
// - a selector acts only when assigned; its active source sets its index bit
// - selector source may be none or any of the six discrete inputs
// - at expert access level, network control word bits 11 to 15 are also allowed
// - remote terminal primary and loop reference off: loop percent is ten times AI over fifteen
// - an unassigned selector is inactive and adds no bit to the index
// - two, four, eight or sixteen speeds use one to four assigned selectors
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module pss_top
  import pss_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register bus
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // selector sources
  input wire logic [5:0] discrete_in,
  input wire logic [15:0] netword,
  // references
  input wire logic [15:0] main_ref,
  input wire logic [15:0] ai_freq,
  // results
  output logic [15:0] speed_ref,
  output logic [3:0] sel_index,
  output logic [15:0] loop_ref_pct,
  output logic loop_ref_valid,
  output logic order_fault
);

  `include "pss_map.svh"

  // state
  pss_bus_state_t state_q;
  pss_bus_state_t state_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [4:0] ctrl_q;
  logic [15:0] source_q;
  logic [5:0] disc_meta_q;
  logic [5:0] disc_sync_q;
  logic [3:0] index_q;
  logic [15:0] loop_ref_q;
  logic loop_valid_q;
  logic order_fault_q;
  logic [15:0] preset_bus_data;

  // control fields
  wire logic [1:0] config_access_level = ctrl_q[`PSS_CTRL_LEVEL_LSB +: 2];
  wire logic [1:0] primary_reference_source = ctrl_q[`PSS_CTRL_PRIM_LSB +: 2];
  wire logic internal_loop_reference = ctrl_q[`PSS_CTRL_LOOPEN_BIT];
  wire logic expert_level = (config_access_level == `PSS_LEVEL_EXPERT);

  // source selection

  // whether a code names a source that may be used at this level
  function automatic logic src_legal(input logic [3:0] code, input logic expert);
    logic ok;
    ok = 1'b0;
    if ((code >= PSS_SRC_DISC1) && (code <= PSS_SRC_DISC6)) begin
      ok = 1'b1;
    end else if ((code >= PSS_SRC_NET11) && (code <= PSS_SRC_NET15)) begin
      ok = expert;
    end
    return ok;
  endfunction

  // level of the source that a code names; none reads low
  function automatic logic src_level(
    input logic [3:0] code,
    input logic [5:0] disc,
    input logic [15:0] nw
  );
    logic lvl;
    lvl = 1'b0;
    case (code)
      PSS_SRC_DISC1: lvl = disc[0];
      PSS_SRC_DISC2: lvl = disc[1];
      PSS_SRC_DISC3: lvl = disc[2];
      PSS_SRC_DISC4: lvl = disc[3];
      PSS_SRC_DISC5: lvl = disc[4];
      PSS_SRC_DISC6: lvl = disc[5];
      PSS_SRC_NET11: lvl = nw[11];
      PSS_SRC_NET12: lvl = nw[12];
      PSS_SRC_NET13: lvl = nw[13];
      PSS_SRC_NET14: lvl = nw[14];
      PSS_SRC_NET15: lvl = nw[15];
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // bit 0 two-speed, 1 four-speed, 2 eight-speed, 3 sixteen-speed
  logic [3:0] sel_assigned;
  logic [3:0] sel_bit;

  for (genvar g = 0; g < 4; g++) begin : g_sel
    wire logic [3:0] code = source_q[g*`PSS_SRC_FIELD_W +: `PSS_SRC_FIELD_W];
    assign sel_assigned[g] = src_legal(code, expert_level);
    assign sel_bit[g] = sel_assigned[g] & src_level(code, disc_sync_q, netword);
  end

  wire logic sel_two_speed = sel_bit[0];
  wire logic sel_four_speed = sel_bit[1];
  wire logic sel_eight_speed = sel_bit[2];
  wire logic sel_sixteen_speed = sel_bit[3];

  // unassigned selectors read zero, so fewer selectors give 2, 4 or 8 speeds
  wire logic [3:0] index_d = {sel_sixteen_speed, sel_eight_speed,
                              sel_four_speed, sel_two_speed};

  // a selector assigned while the one below it is not breaks the order
  wire logic order_fault_d = (sel_assigned[1] & ~sel_assigned[0])
                           | (sel_assigned[2] & ~sel_assigned[1])
                           | (sel_assigned[3] & ~sel_assigned[2]);

  // process-loop reference scaling
  wire logic loop_active = (primary_reference_source == `PSS_PRIM_REMOTE)
                         & ~internal_loop_reference;
  wire logic [19:0] loop_prod = {4'h0, ai_freq} * `PSS_LOOP_MUL;
  wire logic [19:0] loop_quot = loop_prod / `PSS_LOOP_DIV;
  wire logic [15:0] loop_ref_d = loop_active ? loop_quot[15:0] : 16'h0000;

  // bus decode
  wire logic bus_req = avs_read | avs_write;
  wire logic commit = (state_q == PSS_BUS_ANSWER) & avs_write;
  wire logic [3:0] preset_addr = avs_address[5:2];
  wire logic hit_ctrl = (avs_address == `PSS_OFF_CTRL);
  wire logic hit_source = (avs_address == `PSS_OFF_SOURCE);
  wire logic hit_status = (avs_address == `PSS_OFF_STATUS);
  wire logic hit_loopref = (avs_address == `PSS_OFF_LOOPREF);
  wire logic hit_preset = avs_address[`PSS_PRESET_PAGE_BIT]
                        & (avs_address[1:0] == 2'h0)
                        & (preset_addr != 4'h0);
  wire logic wr_ctrl = commit & hit_ctrl & avs_byteenable[0];
  wire logic wr_preset = commit & hit_preset;

  wire logic [15:0] be_mask16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic wr_source = commit & hit_source & (|avs_byteenable[1:0]);

  wire logic [4:0] ctrl_d = wr_ctrl ? avs_writedata[4:0] : ctrl_q;
  wire logic [15:0] source_d = wr_source
                             ? ((source_q & ~be_mask16) | (avs_writedata[15:0] & be_mask16))
                             : source_q;

  wire logic [31:0] status_word = {
    22'h000000,
    loop_valid_q,
    order_fault_q,
    sel_assigned,
    index_q
  };

  wire logic [31:0] rd_mux =
      hit_ctrl ? {27'h0000000, ctrl_q} :
      hit_source ? {16'h0000, source_q} :
      hit_status ? status_word :
      hit_loopref ? {16'h0000, loop_ref_q} :
      hit_preset ? {16'h0000, preset_bus_data} :
      32'h00000000;

  wire logic [31:0] rdata_d = ((state_q == PSS_BUS_FETCH) && avs_read) ? rd_mux : rdata_q;

  // bus state machine: idle, one cycle for the memory fetch, answer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PSS_BUS_IDLE: begin
        if (bus_req) begin
          state_d = PSS_BUS_FETCH;
        end
      end
      PSS_BUS_FETCH: begin
        state_d = PSS_BUS_ANSWER;
      end
      PSS_BUS_ANSWER: begin
        state_d = PSS_BUS_IDLE;
      end
      default: begin
        state_d = PSS_BUS_IDLE;
      end
    endcase
  end

  wire logic wait_d = (state_d != PSS_BUS_ANSWER);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PSS_BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `PSS_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      source_q <= `PSS_SOURCE_RESET;
    end else begin
      source_q <= source_d;
    end
  end

  // discrete input synchroniser and sampled results
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      disc_meta_q <= 6'h00;
      disc_sync_q <= 6'h00;
    end else begin
      disc_meta_q <= discrete_in;
      disc_sync_q <= disc_meta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      index_q <= 4'h0;
    end else begin
      index_q <= index_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      order_fault_q <= 1'b0;
    end else begin
      order_fault_q <= order_fault_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_ref_q <= 16'h0000;
    end else begin
      loop_ref_q <= loop_ref_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_valid_q <= 1'b0;
    end else begin
      loop_valid_q <= loop_active;
    end
  end

  // preset table; slot zero of the speed port is the main reference
  pss_preset_ram u_preset_ram (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(wr_preset),
    .wr_addr(preset_addr),
    .wr_be(avs_byteenable[1:0]),
    .wr_data(avs_writedata[15:0]),
    .sel_addr(index_d),
    .base_data(main_ref),
    .sel_data(speed_ref),
    .bus_addr(preset_addr),
    .bus_data(preset_bus_data)
  );

  // outputs
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign sel_index = index_q;
  assign loop_ref_pct = loop_ref_q;
  assign loop_ref_valid = loop_valid_q;
  assign order_fault = order_fault_q;

endmodule

`default_nettype wire

/* File: testbench/pss_src_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_src_model (
  // clock
  input wire logic sys_clk,
  // levels requested by the bench
  input wire logic [5:0] want_disc,
  input wire logic [15:0] want_net,
  // lines into the block
  output logic [5:0] discrete_in,
  output logic [15:0] netword
);
  initial begin
    discrete_in = 6'h00;
    netword = 16'h0000;
  end
  always @(posedge sys_clk) begin
    discrete_in <= want_disc;
    netword <= want_net;
  end
endmodule

`default_nettype wire

/* File: testbench/pss_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_top_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register bus
  input wire logic [6:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // sources and references
  input wire logic [5:0] discrete_in,
  input wire logic [15:0] netword,
  input wire logic [15:0] main_ref,
  input wire logic [15:0] ai_freq,
  // results
  input wire logic [15:0] speed_ref,
  input wire logic [3:0] sel_index,
  input wire logic [15:0] loop_ref_pct,
  input wire logic loop_ref_valid,
  input wire logic order_fault
);
  logic [4:0] ctl_q;
  logic [15:0] src_q;
  logic [5:0] s1_q, s2_q;
  function automatic logic act(input logic [3:0] c, input logic [5:0] d, input logic [15:0] n,
                               input logic ex);
    if (c >= 4'h1 && c <= 4'h6) return d[c - 4'h1];
    if (c >= 4'h7 && c <= 4'hB) return ex && n[c + 4'h4];
    return 1'b0;
  endfunction
  function automatic logic legal(input logic [3:0] c, input logic ex);
    return (c >= 4'h1 && c <= 4'h6) || (ex && c >= 4'h7 && c <= 4'hB);
  endfunction
  // shadow of the configuration, snooped from committed writes
  wire logic wr_ok = avs_write && !avs_waitrequest;
  wire logic ex = ctl_q[1:0] == 2'h3;
  wire logic loop_on = ctl_q[3:2] == 2'h3 && !ctl_q[4];
  wire logic [3:0] exp_idx = {act(src_q[15:12], s2_q, netword, ex),
    act(src_q[11:8], s2_q, netword, ex), act(src_q[7:4], s2_q, netword, ex),
    act(src_q[3:0], s2_q, netword, ex)};
  // a selector counts as assigned only when its code may act at this level
  wire logic [3:0] asg = {legal(src_q[15:12], ex), legal(src_q[11:8], ex),
    legal(src_q[7:4], ex), legal(src_q[3:0], ex)};
  wire logic ord_bad = (asg[1] && !asg[0]) || (asg[2] && !asg[1]) || (asg[3] && !asg[2]);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 5'h01;
      src_q <= 16'h0043;
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= discrete_in;
      s2_q <= s1_q;
      if (wr_ok && avs_address == 7'h00 && avs_byteenable[0]) ctl_q <= avs_writedata[4:0];
      if (wr_ok && avs_address == 7'h04 && avs_byteenable[0]) src_q[7:0] <= avs_writedata[7:0];
      if (wr_ok && avs_address == 7'h04 && avs_byteenable[1]) src_q[15:8] <= avs_writedata[15:8];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  index_map_a: assert property (sel_index == $past(exp_idx))
    else $error("select index differs from its sources");
  unassigned_bit_a: assert property ($past(src_q[15:12] == 4'h0) |-> !sel_index[3])
    else $error("unassigned selector set its bit");
  net_gate_a: assert property ($past(!ex && src_q[3:0] > 4'h6) |-> !sel_index[0])
    else $error("network source acted below expert level");
  main_ref_a: assert property ($past(reset_n) && sel_index == 4'h0 |-> speed_ref == $past(main_ref))
    else $error("index zero did not give main reference");
  loop_zero_a: assert property (!loop_ref_valid |-> loop_ref_pct == 16'h0000)
    else $error("loop percent nonzero while inactive");
  loop_scale_a: assert property (loop_ref_valid |->
    loop_ref_pct == 16'(({4'h0, $past(ai_freq)} * 20'h0000A) / 20'h0000F))
    else $error("loop percent scaling wrong");
  loop_cond_a: assert property (loop_ref_valid == $past(loop_on))
    else $error("loop valid does not follow its condition");
  order_flag_a: assert property (order_fault == $past(ord_bad))
    else $error("order fault does not follow assignment");
  cover property (sel_index == 4'hF);
  cover property (loop_ref_valid);
  cover property (order_fault);
endmodule

bind pss_top pss_top_checker chk_u (.*);

`default_nettype wire

/* File: testbench/pss_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_top_tb_top;
  logic sys_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [15:0] main_ref = 16'h0ABC, ai_freq = 16'h0000, want_net = 16'h0000;
  logic [5:0] want_disc = 6'h00;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, loop_ref_valid, order_fault;
  wire logic [5:0] discrete_in;
  wire logic [15:0] netword, speed_ref, loop_ref_pct;
  wire logic [3:0] sel_index;
  int num_errors = 0, checked = 0, cycles = 0;
  pss_src_model src_u (.*);
  pss_top dut_u (.*);
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic wr, input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task t_reset;
    bus(0, 7'h00, 32'h0, 4'hF);
    chk("control", rd, 32'h1);
    bus(0, 7'h04, 32'h0, 4'hF);
    chk("source", rd, 32'h43);
    chk("speed", 32'(speed_ref), 32'(main_ref));
  endtask
  task t_presets;
    logic [15:0] tbl [4];
    tbl = '{16'h0001, 16'h0021, 16'h0321, 16'h4321};
    for (int n = 1; n < 16; n++) bus(1, 7'(7'h40 + 4 * n), 32'h1000 + n, 4'hF);
    want_disc <= 6'h3F;
    for (int k = 0; k < 4; k++) begin
      bus(1, 7'h04, 32'(tbl[k]), 4'hF);
      settle(5);
      chk("speeds", 32'(sel_index), (32'h1 << (k + 1)) - 1);
    end
    for (int n = 0; n < 16; n++) begin
      want_disc <= 6'(n);
      settle(5);
      chk("index", 32'(sel_index), n);
      chk("speed", 32'(speed_ref), n == 0 ? 32'(main_ref) : 32'h1000 + n);
    end
  endtask
  task t_network;
    want_disc <= 6'h00;
    want_net <= 16'hF800;
    for (int c = 7; c < 12; c++) begin
      for (int lv = 1; lv < 4; lv += 2) begin
        bus(1, 7'h00, 32'(lv), 4'hF);
        bus(1, 7'h04, 32'(c), 4'hF);
        settle(3);
        chk("netsel", 32'(sel_index), lv == 3);
      end
    end
    want_disc <= 6'h30;
    bus(1, 7'h04, 32'h0065, 4'hF);
    settle(3);
    chk("disc56", 32'(sel_index), 32'h3);
    bus(1, 7'h00, 32'h0, 4'hE);
    bus(0, 7'h00, 32'h0, 4'hF);
    chk("lanes", rd, 32'h3);
  endtask
  task t_loop;
    ai_freq <= 16'hFFFF;
    bus(1, 7'h00, 32'h0F, 4'hF);
    settle(2);
    chk("loopvalid", 32'(loop_ref_valid), 32'h1);
    chk("looppct", 32'(loop_ref_pct), 32'hAAAA);
    bus(0, 7'h0C, 32'h0, 4'hF);
    chk("loopreg", rd, 32'hAAAA);
    bus(1, 7'h00, 32'h1F, 4'hF);
    settle(2);
    chk("loopoff", 32'(loop_ref_pct), 32'h0);
  endtask
  task t_order;
    bus(1, 7'h04, 32'h0100, 4'hF);
    settle(2);
    chk("order8", 32'(order_fault), 32'h1);
    bus(1, 7'h04, 32'h0010, 4'hF);
    settle(2);
    chk("order4", 32'(order_fault), 32'h1);
    bus(1, 7'h04, 32'h0001, 4'hF);
    settle(2);
    chk("orderok", 32'(order_fault), 32'h0);
    bus(0, 7'h40, 32'h0, 4'hF);
    chk("unmapped", rd, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_presets();
    t_network();
    t_loop();
    t_order();
    tally_and_finish();
  end
endmodule

`default_nettype wire
